//--- logic/csw_pkg.sv
// shared constants and types of the channel status word block
package csw_pkg;

  // ----------------------------------------
  // register port
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_CH0_CFG = 8'h10;
  localparam logic [7:0] OFF_CH1_CFG = 8'h14;

  // ----------------------------------------
  // status word layout
  // ----------------------------------------
  localparam int NCH = 2;
  localparam int NOUT = 4;
  localparam int STAT_W = 16;
  localparam int CH_STRIDE = 4;
  localparam int FLD_Z = 0;
  localparam int FLD_ZF = 1;
  localparam int FLD_SEQ = 2;
  localparam int FLD_OUT = 8;

  // ----------------------------------------
  // channel configuration layout
  // ----------------------------------------
  localparam int CFG_W = 24;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_STORE = 3;
  localparam int CFG_TB_LSB = 8;
  localparam int CFG_GATE_LSB = 16;
  localparam logic [23:0] CFG_RST = 24'h000000;

  // ----------------------------------------
  // interrupt layout, two bits per channel
  // ----------------------------------------
  localparam int IRQ_W = 4;
  localparam int IRQ_ZF = 0;
  localparam int IRQ_SEQ = 1;
  localparam logic [3:0] IRQ_RST = 4'h0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SYS_FREQ_HZ = 200_000_000;
  localparam int TB_FREQ_HZ = 5_000_000;
  localparam int TB_DIV = SYS_FREQ_HZ / TB_FREQ_HZ;
  localparam int MS_PER_S = 1000;
  localparam int MS_TICKS = TB_FREQ_HZ / MS_PER_S;
  localparam int CNT_W = 24;
  localparam logic [23:0] SAT_COUNT = 24'hFFFFFF;

  typedef enum logic [2:0] {
    MODE_COUNTER = 3'h0,
    MODE_ENC_X1 = 3'h1,
    MODE_ENC_X2 = 3'h2,
    MODE_ENC_X4 = 3'h3,
    MODE_PWM = 3'h4,
    MODE_PERIOD = 3'h5,
    MODE_CONT = 3'h6,
    MODE_RATE = 3'h7
  } csw_mode_t;

  typedef enum logic [2:0] {
    ST_WAIT = 3'h1,
    ST_ON = 3'h2,
    ST_GATE = 3'h4
  } csw_st_t;

endpackage : csw_pkg

//--- logic/csw_top.sv
// channel status word: z level, zero-frequency flags, update sequence counts, output states
// Operation
// - each channel reports its present z input level, channel 0 in bit 0 and channel 1 in bit 4.
// - the z level bit shows the raw pin level and ignores the z inversion setting.
// - the zero-frequency flag, bits 1 and 5, is live only in period, continuous and rate modes.
// - in period and continuous modes 5 MHz ticks are counted while z is on, and saturation raises the flag.
// - in rate mode pulses are counted over time base times gate interval, and the flag is decided at its end.
// - a 2-bit sequence count per channel, bits 2-3 and 6-7, advances and wraps on every stored word update.
// - bits 8 to 11 show outputs 0 to 3, one when on.
// - counter and encoder modes without a store mode never update, so the sequence count holds.
`timescale 1ns/1ps

// ----------------------------------------
// one counting channel
// ----------------------------------------
module csw_chan #(
  parameter int MS_TICKS = csw_pkg::MS_TICKS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // timebase and z input
  input wire logic tb_tick,
  input wire logic z_lvl,
  input wire logic z_rise,
  input wire logic store_evt,
  // configuration
  input wire csw_pkg::csw_mode_t mode,
  input wire logic store_sel,
  input wire logic [7:0] tb_ms,
  input wire logic [7:0] gate,
  // state
  output logic zf,
  output logic [1:0] seq,
  output logic zf_set,
  output logic upd
);
  localparam int MSD_W = $clog2(MS_TICKS);
  localparam logic [23:0] SAT_M1 = csw_pkg::SAT_COUNT - 24'h000001;

  typedef struct packed {
    csw_pkg::csw_st_t st;
    logic [23:0] cnt;
    logic [MSD_W-1:0] msd;
    logic [15:0] ms;
    logic zf;
    logic [1:0] seq;
    logic zf_set;
    logic upd;
  } csw_chan_t;

  csw_chan_t s;
  csw_chan_t n;
  logic freq;
  logic ms_tick;
  logic [15:0] ivl;
  logic [15:0] ivl_last;

  if (MS_TICKS < 2) begin : g_chk
    $error("MS_TICKS must be at least 2");
  end

  assign freq = mode >= csw_pkg::MODE_PERIOD;
  assign ms_tick = tb_tick && (s.msd == MSD_W'(MS_TICKS - 1));
  assign ivl = 16'(tb_ms * gate);
  // a zero interval would never close, so it acts as one millisecond
  assign ivl_last = (ivl == 16'h0000) ? 16'h0000 : ivl - 16'h0001;

  always_comb begin
    n = s;
    n.zf_set = 1'b0;
    n.upd = 1'b0;
    if (!freq) begin
      n.st = csw_pkg::ST_WAIT;
      n.cnt = '0;
      n.msd = '0;
      n.ms = '0;
      n.zf = 1'b0;
      // pwm stores every period; counters only with a store mode
      n.upd = store_evt && (store_sel || mode == csw_pkg::MODE_PWM);
    end else if (mode == csw_pkg::MODE_RATE) begin
      if (s.st != csw_pkg::ST_GATE) begin
        n.st = csw_pkg::ST_GATE;
        n.cnt = '0;
        n.msd = '0;
        n.ms = '0;
      end else begin
        if (tb_tick) begin
          n.msd = ms_tick ? '0 : s.msd + 1'b1;
        end
        if (z_rise && s.cnt != csw_pkg::SAT_COUNT) begin
          n.cnt = s.cnt + 1'b1;
        end
        if (ms_tick) begin
          n.ms = s.ms + 1'b1;
          if (s.ms >= ivl_last) begin
            // interval closes: decide the flag from the pulses seen
            n.ms = '0;
            n.upd = 1'b1;
            n.cnt = '0;
            n.zf = (s.cnt == '0) && !z_rise;
            n.zf_set = n.zf && !s.zf;
          end
        end
      end
    end else begin
      case (s.st)
        csw_pkg::ST_ON: begin
          if (!z_lvl) begin
            n.st = csw_pkg::ST_WAIT;
            n.upd = 1'b1;
            if (s.cnt != csw_pkg::SAT_COUNT) begin
              n.zf = 1'b0;
            end
          end else if (tb_tick && s.cnt != csw_pkg::SAT_COUNT) begin
            n.cnt = s.cnt + 1'b1;
            if (s.cnt == SAT_M1) begin
              n.zf = 1'b1;
              n.zf_set = !s.zf;
            end
          end
        end
        csw_pkg::ST_WAIT: begin
          if (z_rise) begin
            n.st = csw_pkg::ST_ON;
            n.cnt = '0;
          end
        end
        default: begin
          n.st = csw_pkg::ST_WAIT;
          n.cnt = '0;
        end
      endcase
    end
    if (n.upd) begin
      n.seq = s.seq + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{st: csw_pkg::ST_WAIT, default: '0};
    end else begin
      s <= n;
    end
  end

  assign zf = s.zf;
  assign seq = s.seq;
  assign zf_set = s.zf_set;
  assign upd = s.upd;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_rate_close;
    (mode == csw_pkg::MODE_RATE) && s.upd;
  endsequence

  AST_SEQ_INC: assert property (@(posedge sys_clk) disable iff (!rstn)
    s.upd |-> s.seq == $past(s.seq) + 2'h1)
    else $error("sequence count did not advance on update");

  AST_SEQ_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
    (mode < csw_pkg::MODE_PWM && !store_sel) ##1 (mode < csw_pkg::MODE_PWM) |-> $stable(s.seq))
    else $error("sequence count moved without a store mode");

  AST_ZF_ONLY_FREQ: assert property (@(posedge sys_clk) disable iff (!rstn)
    !freq |=> !s.zf)
    else $error("zero-frequency flag outside frequency modes");

  AST_ZF_SAT: assert property (@(posedge sys_clk) disable iff (!rstn)
    (s.st == csw_pkg::ST_ON && s.cnt == csw_pkg::SAT_COUNT && mode != csw_pkg::MODE_RATE && freq) |-> s.zf)
    else $error("saturated count without zero-frequency flag");

  AST_RATE_DECIDE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (mode == csw_pkg::MODE_RATE) ##1 ((mode == csw_pkg::MODE_RATE) && $rose(s.zf)) |-> s_rate_close)
    else $error("rate flag raised outside an interval end");

  AST_ZF_CLEAR: assert property (@(posedge sys_clk) disable iff (!rstn)
    freq ##1 (freq && $fell(s.zf)) |-> s.upd)
    else $error("zero-frequency flag cleared without a measurement");

  // the interrupt only sees the one-cycle event, never the level
  AST_ZF_EVT: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(s.zf) |-> s.zf_set)
    else $error("zero-frequency flag rose without its event");

endmodule : csw_chan

// ----------------------------------------
// top: sync, timebase, registers, interrupt
// ----------------------------------------
module csw_top #(
  parameter int MS_TICKS = csw_pkg::MS_TICKS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // field and datapath
  input wire logic [1:0] z_pin,
  input wire logic [1:0] store_evt,
  input wire logic [3:0] out_state,
  // interrupt
  output logic irq
);
  localparam int TBD_W = $clog2(csw_pkg::TB_DIV);

  typedef struct packed {
    logic [1:0] z_s1;
    logic [1:0] z_s2;
    logic [1:0] z_d;
    logic [TBD_W-1:0] tb_div;
    logic tb_tick;
    logic [1:0][23:0] cfg;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] rdata;
    logic irq;
  } csw_top_t;

  csw_top_t s;
  csw_top_t n;
  logic [1:0] ch_zf;
  logic [1:0][1:0] ch_seq;
  logic [1:0] ch_zf_set;
  logic [1:0] ch_upd;
  logic [15:0] stat_word;
  logic [3:0] evt;
  logic [3:0] clr;

  if (csw_pkg::TB_DIV < 2) begin : g_chk
    $error("timebase divider must be at least 2");
  end

  for (genvar g = 0; g < csw_pkg::NCH; g++) begin : g_ch
    csw_chan #(.MS_TICKS(MS_TICKS)) u_chan (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .tb_tick(s.tb_tick),
      .z_lvl(s.z_s2[g]),
      .z_rise(s.z_s2[g] && !s.z_d[g]),
      .store_evt(store_evt[g]),
      .mode(csw_pkg::csw_mode_t'(s.cfg[g][csw_pkg::CFG_MODE_LSB +: 3])),
      .store_sel(s.cfg[g][csw_pkg::CFG_STORE]),
      .tb_ms(s.cfg[g][csw_pkg::CFG_TB_LSB +: 8]),
      .gate(s.cfg[g][csw_pkg::CFG_GATE_LSB +: 8]),
      .zf(ch_zf[g]),
      .seq(ch_seq[g]),
      .zf_set(ch_zf_set[g]),
      .upd(ch_upd[g])
    );
  end

  always_comb begin
    stat_word = '0;
    evt = '0;
    for (int c = 0; c < csw_pkg::NCH; c++) begin
      // raw synchronised level, inversion never applied here
      stat_word[c * csw_pkg::CH_STRIDE + csw_pkg::FLD_Z] = s.z_s2[c];
      stat_word[c * csw_pkg::CH_STRIDE + csw_pkg::FLD_ZF] = ch_zf[c];
      stat_word[c * csw_pkg::CH_STRIDE + csw_pkg::FLD_SEQ +: 2] = ch_seq[c];
      evt[c * 2 + csw_pkg::IRQ_ZF] = ch_zf_set[c];
      evt[c * 2 + csw_pkg::IRQ_SEQ] = ch_upd[c];
    end
    stat_word[csw_pkg::FLD_OUT +: csw_pkg::NOUT] = out_state;
  end

  always_comb begin
    n = s;
    clr = '0;
    n.z_s1 = z_pin;
    n.z_s2 = s.z_s1;
    n.z_d = s.z_s2;
    n.tb_tick = s.tb_div == TBD_W'(csw_pkg::TB_DIV - 1);
    n.tb_div = n.tb_tick ? '0 : s.tb_div + 1'b1;
    if (reg_wr) begin
      case (reg_addr)
        csw_pkg::OFF_CH0_CFG: n.cfg[0] = reg_wdata[23:0];
        csw_pkg::OFF_CH1_CFG: n.cfg[1] = reg_wdata[23:0];
        csw_pkg::OFF_IRQ_MASK: n.irq_mask = reg_wdata[3:0];
        csw_pkg::OFF_IRQ_STAT: clr = reg_wdata[3:0];
        default: ;
      endcase
    end
    // a new event in the clearing cycle survives the clear
    n.irq_stat = (s.irq_stat & ~clr) | evt;
    n.irq = |(n.irq_stat & n.irq_mask);
    n.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        csw_pkg::OFF_STATUS: n.rdata = {16'h0000, stat_word};
        csw_pkg::OFF_IRQ_STAT: n.rdata = {28'h0000000, s.irq_stat};
        csw_pkg::OFF_IRQ_MASK: n.rdata = {28'h0000000, s.irq_mask};
        csw_pkg::OFF_CH0_CFG: n.rdata = {8'h00, s.cfg[0]};
        csw_pkg::OFF_CH1_CFG: n.rdata = {8'h00, s.cfg[1]};
        default: n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{cfg: {csw_pkg::CFG_RST, csw_pkg::CFG_RST}, irq_stat: csw_pkg::IRQ_RST,
             irq_mask: csw_pkg::IRQ_RST, default: '0};
    end else begin
      s <= n;
    end
  end

  assign reg_rdata = s.rdata;
  assign irq = s.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_stat_rd;
    reg_rd && (reg_addr == csw_pkg::OFF_STATUS);
  endsequence

  AST_Z_LEVEL: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_stat_rd |=> (reg_rdata[0] == $past(s.z_s2[0])) && (reg_rdata[4] == $past(s.z_s2[1])))
    else $error("z level bits do not follow the pins");

  AST_OUT_STATE: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_stat_rd |=> reg_rdata[11:8] == $past(out_state))
    else $error("output state bits wrong");

  AST_SEQ_READ: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_stat_rd |=> (reg_rdata[3:2] == $past(ch_seq[0])) && (reg_rdata[7:6] == $past(ch_seq[1])))
    else $error("sequence bits misplaced in the status word");

  AST_EVT_STICKY: assert property (@(posedge sys_clk) disable iff (!rstn)
    (evt != 4'h0) |=> (s.irq_stat & $past(evt)) == $past(evt))
    else $error("event lost against a clear");

endmodule : csw_top

//--- sim/csw_host.sv
// polling controller model: register-port master for the status word block
`timescale 1ns/1ps

module csw_host (
  // clock
  input wire logic sys_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // idle address and data are inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // one read per call; in test_seq_irq the bench lets five ch0 updates pass between two reads, so the sequence count wraps unseen
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd

endmodule : csw_host

//--- sim/counter_channel_status_word_bench.sv
// self-checking bench of the channel status word block
`timescale 1ns/1ps

module counter_channel_status_word_bench;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [1:0] z_pin = 2'h0;
  logic [1:0] store_evt = 2'h0;
  logic [3:0] out_state = 4'h0;
  logic irq;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #2.5 sys_clk = ~sys_clk;

  csw_host host_u (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // short millisecond so one rate interval is 160 clocks
  csw_top #(.MS_TICKS(4)) dut_u (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .z_pin(z_pin), .store_evt(store_evt),
    .out_state(out_state), .irq(irq));

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
    logic [31:0] d;
    host_u.rd(a, d);
    check(what, d & msk, exp);
  endtask : rd_chk

  task automatic pulse(input int ch, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      store_evt[ch] <= 1'b1;
      @(posedge sys_clk);
      store_evt[ch] <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask : pulse

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      num_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset_map();
    logic [7:0] offs [6];
    offs = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h40};
    check("irq after reset", {31'h0, irq}, 32'h00000000);
    foreach (offs[i]) rd_chk("reset value", offs[i], 32'hFFFFFFFF, 32'h00000000);
    host_u.wr(8'h08, 32'h0000FFFF);
    host_u.wr(8'h40, 32'hFFFFFFFF);
    rd_chk("status read-only", 8'h08, 32'hFFFFFFFF, 32'h00000000);
    rd_chk("unmapped read", 8'h40, 32'hFFFFFFFF, 32'h00000000);
  endtask : test_reset_map

  task automatic test_levels();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      z_pin <= 2'(i);
      out_state <= 4'(i * 5 + 1);
      repeat (4) @(posedge sys_clk);
      rd_chk("z and outputs", 8'h08, 32'h00000F11, {20'h0, 4'(i * 5 + 1), 3'h0, 1'(i >> 1), 3'h0, 1'(i)});
    end
    @(posedge sys_clk);
    z_pin <= 2'h0;
    out_state <= 4'h0;
    repeat (4) @(posedge sys_clk);
  endtask : test_levels

  task automatic test_seq_irq();
    // encoder mode without store behaves like the plain counter
    host_u.wr(8'h10, 32'h00000003);
    pulse(0, 3);
    rd_chk("seq held without store", 8'h08, 32'h0000000C, 32'h00000000);
    rd_chk("no irq without update", 8'h04, 32'h0000000F, 32'h00000000);
    host_u.wr(8'h0C, 32'h00000002);
    host_u.wr(8'h10, 32'h00000008);
    pulse(0, 5);
    rd_chk("seq wrap ch0", 8'h08, 32'h0000000C, 32'h00000004);
    rd_chk("irq status update", 8'h04, 32'h0000000F, 32'h00000002);
    check("irq raised", {31'h0, irq}, 32'h00000001);
    host_u.wr(8'h0C, 32'h00000000);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check("irq masked", {31'h0, irq}, 32'h00000000);
    host_u.wr(8'h0C, 32'h00000002);
    host_u.wr(8'h04, 32'h00000002);
    repeat (2) @(posedge sys_clk);
    rd_chk("irq status cleared", 8'h04, 32'h0000000F, 32'h00000000);
    check("irq cleared", {31'h0, irq}, 32'h00000000);
    host_u.wr(8'h14, 32'h00000004);
    pulse(1, 2);
    rd_chk("seq pwm ch1", 8'h08, 32'h000000CC, 32'h00000084);
  endtask : test_seq_irq

  task automatic test_rate();
    host_u.wr(8'h10, 32'h00010107);
    repeat (90) @(posedge sys_clk);
    rd_chk("zf before interval end", 8'h08, 32'h00000002, 32'h00000000);
    repeat (200) @(posedge sys_clk);
    rd_chk("zf after empty interval", 8'h08, 32'h00000002, 32'h00000002);
    rd_chk("zf irq status", 8'h04, 32'h00000001, 32'h00000001);
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      z_pin[0] <= ~z_pin[0];
      repeat (20) @(posedge sys_clk);
    end
    rd_chk("zf cleared by pulses", 8'h08, 32'h00000002, 32'h00000000);
    // flag set again first, or the counter-mode check could not fail
    repeat (330) @(posedge sys_clk);
    rd_chk("zf set again", 8'h08, 32'h00000002, 32'h00000002);
    host_u.wr(8'h10, 32'h00000000);
    repeat (300) @(posedge sys_clk);
    rd_chk("zf forced off in counter mode", 8'h08, 32'h00000002, 32'h00000000);
  endtask : test_rate

  task automatic test_period();
    logic [31:0] d;
    // empty rate interval first, so the measurement has a flag to clear
    host_u.wr(8'h14, 32'h00010107);
    repeat (330) @(posedge sys_clk);
    rd_chk("ch1 zf after empty interval", 8'h08, 32'h00000020, 32'h00000020);
    host_u.wr(8'h14, 32'h00000005);
    host_u.rd(8'h08, d);
    for (int m = 5; m < 7; m++) begin
      host_u.wr(8'h14, 32'(m));
      repeat (10) @(posedge sys_clk);
      z_pin[1] <= 1'b1;
      repeat (200) @(posedge sys_clk);
      z_pin[1] <= 1'b0;
      repeat (20) @(posedge sys_clk);
      rd_chk("period update and zf", 8'h08, 32'h000000F0, {24'h0, 2'(d[7:6] + 2'(m - 4)), 6'h00});
    end
  endtask : test_period

  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    test_reset_map();
    test_levels();
    test_seq_irq();
    test_rate();
    test_period();
    print_verdict();
  end

endmodule : counter_channel_status_word_bench
